/* File: hw/enable_latch_pkg.sv */
package enable_latch_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int BUS_W = 8;
	localparam int CH_N = 4;

	// ----------------------------------------
	// Reset values of the three latches
	// ----------------------------------------
	localparam logic [7:0] DRIVER_RST = 8'h00;
	localparam logic [7:0] SELFTEST_RST = 8'hff;
	localparam logic [7:0] RXPOWER_RST = 8'h00;

	// ----------------------------------------
	// Register file: mapping tables, latch states and fault readback
	// ----------------------------------------
	localparam logic [3:0] ADDR_DRV_MAP = 4'h0;
	localparam logic [3:0] ADDR_TST_MAP = 4'h1;
	localparam logic [3:0] ADDR_RXP_MAP = 4'h2;
	localparam logic [3:0] ADDR_DRV_STATE = 4'h3;
	localparam logic [3:0] ADDR_TST_STATE = 4'h4;
	localparam logic [3:0] ADDR_RXP_STATE = 4'h5;
	localparam logic [3:0] ADDR_FAULT = 4'h6;

	// Bit-select mapping: 3 bits per channel, packed low to high
	localparam int SEL_W = 3;
	localparam int MAP_W = 12;
	// Driver: channels use bus bits 0..3
	localparam logic [11:0] DRV_MAP_RST = 12'h688;
	// Self-test: tx on 0..3, rx on 4..7, sharing one 24-bit map
	localparam logic [23:0] TST_MAP_RST = 24'hfac688;
	// Receive power: channels use bus bits 4..7
	localparam logic [11:0] RXP_MAP_RST = 12'hfac;

	typedef enum logic [1:0] {
		LATCH_OPEN = 2'b01,
		LATCH_HELD = 2'b10
	} latch_state_e;

endpackage

/* File: hw/latch_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface latch_if;
	logic strobe;
	logic [7:0] bus;
	logic [7:0] value;
	modport owner (output strobe, output bus, input value);
	modport latch (input strobe, input bus, output value);
endinterface
`default_nettype wire

/* File: hw/strobe_latch.sv */
`timescale 1ns/1ps
`default_nettype none
module strobe_latch #(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clear,
	latch_if.latch lif
);
	enable_latch_pkg::latch_state_e state_reg;
	enable_latch_pkg::latch_state_e state_next;
	logic [7:0] hold_reg;
	logic [7:0] hold_next;

	// ----------------------------------------
	// Transparent while open, hold on fall
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		hold_next = hold_reg;
		unique case (state_reg)
			enable_latch_pkg::LATCH_OPEN:
			begin
				// Bus on the falling edge is already stale
				if (lif.strobe)
				begin
					hold_next = lif.bus;
				end
				else
				begin
					state_next = enable_latch_pkg::LATCH_HELD;
				end
			end
			enable_latch_pkg::LATCH_HELD:
			begin
				if (lif.strobe)
				begin
					state_next = enable_latch_pkg::LATCH_OPEN;
					hold_next = lif.bus;
				end
			end
			default:
			begin
				state_next = enable_latch_pkg::LATCH_HELD;
			end
		endcase
		// Reset only takes a closed latch
		if (clear && !lif.strobe)
		begin
			hold_next = RESET_VALUE;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= enable_latch_pkg::LATCH_HELD;
			hold_reg <= RESET_VALUE;
		end
		else
		begin
			state_reg <= state_next;
			hold_reg <= hold_next;
		end
	end

	assign lif.value = hold_reg;
endmodule
`default_nettype wire

/* File: hw/channel_enable_latch_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [R01] A high driver strobe passes the shared bus into the driver enables.
// [R02] A high driver enable turns the channel driver on, low powers it down.
// [R03] The driver latch holds the bus value seen as its strobe falls.
// [R04] Device reset clears the driver latch, disabling every driver.
// [R05] A high self-test strobe passes the shared bus into the self-test enables.
// [R06] A low self-test bit puts that tx channel into generation or rx into compare.
// [R07] A high self-test bit returns that channel to normal traffic.
// [R08] The self-test latch holds the bus value seen as its strobe falls.
// [R09] Device reset clears the self-test latch only while it is closed.
// [R10] A high receive strobe passes the shared bus into the receive power enables.
// [R11] A high receive power bit keeps that receiver on, low powers it down.
// [R12] The receive power latch holds the bus value seen as its strobe falls.
// [R13] Device reset clears the receive power latch, disabling all receivers.
// [R14] Device reset is active low, sampled on the clock, and clears the driver and receive power latches, and the self-test latch only while closed.
// [R15] Link fault is asserted low for a channel whose receiver is powered down.
// [R16] The bus bit behind each channel enable comes from a writable mapping table.
module channel_enable_latch_bank (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic device_reset_n,
	input wire logic driver_enable_strobe,
	input wire logic selftest_enable_strobe,
	input wire logic receive_power_strobe,
	input wire logic [7:0] shared_enable_bus,
	input wire logic [3:0] rx_freq_fault,
	input wire logic [3:0] rx_amplitude_fault,
	input wire logic [3:0] rx_density_fault,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [3:0] serial_out_driver,
	output logic [3:0] tx_selftest_run,
	output logic [3:0] rx_selftest_run,
	output logic [3:0] rx_power_on,
	output logic [3:0] link_fault_n
);
	// ----------------------------------------
	// Select one bus bit per channel
	// ----------------------------------------
	function automatic logic [3:0] pick(input logic [7:0] v, input logic [11:0] map);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < enable_latch_pkg::CH_N; i++)
		begin
			r[i] = v[map[i*enable_latch_pkg::SEL_W +: enable_latch_pkg::SEL_W]];
		end
		return r;
	endfunction

	latch_if drv_if();
	latch_if tst_if();
	latch_if rxp_if();

	logic reset_sample_reg;
	logic reset_sample_next;
	logic [11:0] drv_map_reg;
	logic [11:0] drv_map_next;
	logic [23:0] tst_map_reg;
	logic [23:0] tst_map_next;
	logic [11:0] rxp_map_reg;
	logic [11:0] rxp_map_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [3:0] drv_reg;
	logic [3:0] drv_next;
	logic [3:0] txt_reg;
	logic [3:0] txt_next;
	logic [3:0] rxt_reg;
	logic [3:0] rxt_next;
	logic [3:0] rxp_reg;
	logic [3:0] rxp_next;
	logic [3:0] fault_reg;
	logic [3:0] fault_next;
	logic [3:0] rx_on;

	// ----------------------------------------
	// Latches
	// ----------------------------------------
	// [R01] [R04] driver strobe path, closed by reset
	assign drv_if.strobe = driver_enable_strobe & ~reset_sample_reg;
	// [R05] [R09] self-test strobe path, reset waits for close
	assign tst_if.strobe = selftest_enable_strobe;
	// [R10] [R13] receive strobe path, closed by reset
	assign rxp_if.strobe = receive_power_strobe & ~reset_sample_reg;
	assign drv_if.bus = shared_enable_bus;
	assign tst_if.bus = shared_enable_bus;
	assign rxp_if.bus = shared_enable_bus;

	// [R14] reset sampled on clock
	always_comb
	begin
		reset_sample_next = !device_reset_n;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			reset_sample_reg <= 1'b0;
		end
		else
		begin
			reset_sample_reg <= reset_sample_next;
		end
	end

	// [R03] [R04] driver latch
	strobe_latch #(.RESET_VALUE(enable_latch_pkg::DRIVER_RST)) drv_latch (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(reset_sample_reg),
		.lif(drv_if)
	);

	// [R08] [R09] self-test latch
	strobe_latch #(.RESET_VALUE(enable_latch_pkg::SELFTEST_RST)) tst_latch (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(reset_sample_reg),
		.lif(tst_if)
	);

	// [R12] [R13] receive power latch; cleared even while open
	strobe_latch #(.RESET_VALUE(enable_latch_pkg::RXPOWER_RST)) rxp_latch (
		.sys_clk(sys_clk),
		.rst(rst),
		.clear(reset_sample_reg),
		.lif(rxp_if)
	);

	// ----------------------------------------
	// Channel outputs
	// ----------------------------------------
	always_comb
	begin
		// [R16] mapped bit selection
		rx_on = pick(rxp_if.value, rxp_map_reg);
		// [R02] driver on when high
		drv_next = pick(drv_if.value, drv_map_reg);
		// [R06] [R07] low bit runs self-test
		txt_next = ~pick(tst_if.value, tst_map_reg[11:0]);
		rxt_next = ~pick(tst_if.value, tst_map_reg[23:12]);
		// [R11] receiver power
		rxp_next = rx_on;
		// [R15] four-term fault OR
		fault_next = ~(~rx_on | rx_freq_fault | rx_amplitude_fault | rx_density_fault);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			drv_reg <= 4'h0;
			txt_reg <= 4'h0;
			rxt_reg <= 4'h0;
			rxp_reg <= 4'h0;
			fault_reg <= 4'h0;
		end
		else
		begin
			drv_reg <= drv_next;
			txt_reg <= txt_next;
			rxt_reg <= rxt_next;
			rxp_reg <= rxp_next;
			fault_reg <= fault_next;
		end
	end

	assign serial_out_driver = drv_reg;
	assign tx_selftest_run = txt_reg;
	assign rx_selftest_run = rxt_reg;
	assign rx_power_on = rxp_reg;
	assign link_fault_n = fault_reg;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	always_comb
	begin
		drv_map_next = drv_map_reg;
		tst_map_next = tst_map_reg;
		rxp_map_next = rxp_map_reg;
		rdata_next = 32'h0;
		// [R16] mapping tables writable
		if (reg_wr)
		begin
			unique case (reg_addr)
				enable_latch_pkg::ADDR_DRV_MAP: drv_map_next = reg_wdata[11:0];
				enable_latch_pkg::ADDR_TST_MAP: tst_map_next = reg_wdata[23:0];
				enable_latch_pkg::ADDR_RXP_MAP: rxp_map_next = reg_wdata[11:0];
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				enable_latch_pkg::ADDR_DRV_MAP: rdata_next = {20'h0, drv_map_reg};
				enable_latch_pkg::ADDR_TST_MAP: rdata_next = {8'h0, tst_map_reg};
				enable_latch_pkg::ADDR_RXP_MAP: rdata_next = {20'h0, rxp_map_reg};
				enable_latch_pkg::ADDR_DRV_STATE: rdata_next = {24'h0, drv_if.value};
				enable_latch_pkg::ADDR_TST_STATE: rdata_next = {24'h0, tst_if.value};
				enable_latch_pkg::ADDR_RXP_STATE: rdata_next = {24'h0, rxp_if.value};
				enable_latch_pkg::ADDR_FAULT: rdata_next = {28'h0, fault_reg};
				default: rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			drv_map_reg <= enable_latch_pkg::DRV_MAP_RST;
			tst_map_reg <= enable_latch_pkg::TST_MAP_RST;
			rxp_map_reg <= enable_latch_pkg::RXP_MAP_RST;
			rdata_reg <= 32'h0;
		end
		else
		begin
			drv_map_reg <= drv_map_next;
			tst_map_reg <= tst_map_next;
			rxp_map_reg <= rxp_map_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

/* File: dv/latch_bank_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module latch_bank_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic device_reset_n,
	input wire logic driver_enable_strobe,
	input wire logic selftest_enable_strobe,
	input wire logic receive_power_strobe,
	input wire logic [7:0] shared_enable_bus,
	input wire logic [3:0] rx_freq_fault,
	input wire logic [3:0] rx_amplitude_fault,
	input wire logic [3:0] rx_density_fault,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [3:0] serial_out_driver,
	input wire logic [3:0] tx_selftest_run,
	input wire logic [3:0] rx_selftest_run,
	input wire logic [3:0] rx_power_on,
	input wire logic [3:0] link_fault_n
);
	// ----------------------------------------
	// Properties, default channel maps assumed
	// ----------------------------------------
	wire logic [3:0] any_fault = rx_freq_fault | rx_amplitude_fault | rx_density_fault;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_drv_follow: assert property (driver_enable_strobe && $past(device_reset_n) |->
		##2 serial_out_driver == $past(shared_enable_bus[3:0], 2)) else $error("driver open");
	a_drv_hold: assert property ((!driver_enable_strobe && device_reset_n)[*3] |=>
		$stable(serial_out_driver)) else $error("driver hold");
	a_tst_follow: assert property (selftest_enable_strobe |-> ##2
		{rx_selftest_run, tx_selftest_run} == ~$past(shared_enable_bus, 2)) else $error("test");
	a_rxp_follow: assert property (receive_power_strobe && $past(device_reset_n) |->
		##2 rx_power_on == $past(shared_enable_bus[7:4], 2)) else $error("rx power open");
	a_drv_clear: assert property ((!device_reset_n ##1 !driver_enable_strobe) |->
		##2 serial_out_driver == 4'h0) else $error("driver clear");
	a_tst_clear: assert property ((!device_reset_n ##1 !selftest_enable_strobe) |->
		##2 (tx_selftest_run | rx_selftest_run) == 4'h0) else $error("test clear");
	a_rxp_clear: assert property ((!device_reset_n ##1 !receive_power_strobe) |->
		##2 rx_power_on == 4'h0) else $error("rx power clear");
	a_fault_out: assert property (link_fault_n == (rx_power_on & ~$past(any_fault)))
		else $error("link fault");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data idle");
endmodule
bind channel_enable_latch_bank latch_bank_checker u_chk (.*);
`default_nettype wire

/* File: dv/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic sys_clk,
	output logic driver_enable_strobe,
	output logic selftest_enable_strobe,
	output logic receive_power_strobe,
	output logic [7:0] shared_enable_bus
);
	// ----------------------------------------
	// Latch loading
	// ----------------------------------------
	initial
	begin
		{driver_enable_strobe, selftest_enable_strobe, receive_power_strobe} = 3'h0;
		shared_enable_bus = 8'h00;
	end
	task automatic load(input int sel, input logic [7:0] val);
		@(posedge sys_clk);
		driver_enable_strobe <= (sel == 0);
		selftest_enable_strobe <= (sel == 1);
		receive_power_strobe <= (sel == 2);
		shared_enable_bus <= ~val;
		@(posedge sys_clk);
		shared_enable_bus <= val;
		@(posedge sys_clk);
		{driver_enable_strobe, selftest_enable_strobe, receive_power_strobe} <= 3'h0;
		// Released bus inverted, hold must ignore it
		@(posedge sys_clk);
		shared_enable_bus <= ~val;
	endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic sys_clk, rst, device_reset_n, reg_wr, reg_rd;
	logic [3:0] rx_freq_fault, rx_amplitude_fault, rx_density_fault, reg_addr;
	logic [31:0] reg_wdata, d;
	wire logic ds, ts, rs;
	wire logic [7:0] bus;
	wire logic [31:0] reg_rdata;
	wire logic [3:0] drv, txr, rxr, pwr, lfn;
	int n_errors, check_count;
	always #20 sys_clk = ~sys_clk;
	host_model u_host (.sys_clk(sys_clk), .driver_enable_strobe(ds),
		.selftest_enable_strobe(ts), .receive_power_strobe(rs), .shared_enable_bus(bus));
	channel_enable_latch_bank u_dut (.sys_clk(sys_clk), .rst(rst),
		.device_reset_n(device_reset_n), .driver_enable_strobe(ds),
		.selftest_enable_strobe(ts), .receive_power_strobe(rs), .shared_enable_bus(bus),
		.rx_freq_fault(rx_freq_fault), .rx_amplitude_fault(rx_amplitude_fault),
		.rx_density_fault(rx_density_fault), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_out_driver(drv),
		.tx_selftest_run(txr), .rx_selftest_run(rxr), .rx_power_on(pwr), .link_fault_n(lfn));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task settle;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask
	task report_and_stop;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset_state;
		chk("drv", 4'h0, drv);
		chk("pwr", 4'h0, pwr);
		rd(enable_latch_pkg::ADDR_TST_MAP);
		chk("tmap", 32'hfac688, d);
		rd(enable_latch_pkg::ADDR_TST_STATE);
		chk("tst", 32'hff, d);
	endtask
	task t_latches;
		u_host.load(0, 8'ha5);
		settle;
		chk("drv", 4'h5, drv);
		u_host.load(1, 8'h3c);
		settle;
		chk("tx", 4'h3, txr);
		chk("rx", 4'hc, rxr);
		u_host.load(2, 8'h50);
		settle;
		chk("pwr", 4'h5, pwr);
		chk("drv", 4'h5, drv);
	endtask
	task t_faults;
		@(posedge sys_clk);
		rx_freq_fault <= 4'h1;
		rx_density_fault <= 4'h4;
		settle;
		chk("lfn", 4'h0, lfn);
		@(posedge sys_clk);
		{rx_freq_fault, rx_density_fault} <= 8'h00;
		settle;
		chk("lfn", 4'h5, lfn);
	endtask
	task t_dev_reset;
		@(posedge sys_clk);
		device_reset_n <= 1'b0;
		@(posedge sys_clk);
		device_reset_n <= 1'b1;
		settle;
		chk("drv", 4'h0, drv);
		chk("tst", 4'h0, txr | rxr);
		chk("pwr", 4'h0, pwr);
		chk("lfn", 4'h0, lfn);
	endtask
	task t_regs;
		wr(4'hf, 32'hffffffff);
		wr(enable_latch_pkg::ADDR_FAULT, 32'hf);
		rd(4'hf);
		chk("unmapped", 32'h0, d);
		rd(enable_latch_pkg::ADDR_FAULT);
		chk("fault reg", 32'h0, d);
	endtask
	initial
	begin
		{sys_clk, rst, device_reset_n, reg_wr, reg_rd} = 5'b01100;
		{rx_freq_fault, rx_amplitude_fault, rx_density_fault, reg_addr} = 16'h0;
		{reg_wdata, n_errors, check_count} = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset_state;
		t_latches;
		t_faults;
		t_dev_reset;
		t_regs;
		report_and_stop;
	end
	// Whole run is about 56 cycles
	initial
	begin
		repeat (2000) @(posedge sys_clk);
		n_errors++;
		report_and_stop;
	end
endmodule
`default_nettype wire
